// *** imsh_cfg.svh ***
// Constants of the two-wire bus controller: control bit positions, condition codes,
// reset values and byte framing.
// Assumes it is included by bare name from the package and the design module.
`ifndef IMSH_CFG_SVH
`define IMSH_CFG_SVH

// Bit positions inside the control byte
`define IMSH_BIT_AA 2
`define IMSH_BIT_SI 3
`define IMSH_BIT_STO 4
`define IMSH_BIT_STA 5
`define IMSH_BIT_EN 6

// Condition codes reported to software
`define IMSH_SC_BUS_ERR 8'h00
`define IMSH_SC_START 8'h08
`define IMSH_SC_RSTART 8'h10
`define IMSH_SC_MT_SLA_ACK 8'h18
`define IMSH_SC_MT_SLA_NACK 8'h20
`define IMSH_SC_MT_DAT_ACK 8'h28
`define IMSH_SC_MT_DAT_NACK 8'h30
`define IMSH_SC_ARB_LOST 8'h38
`define IMSH_SC_MR_SLA_ACK 8'h40
`define IMSH_SC_MR_SLA_NACK 8'h48
`define IMSH_SC_MR_DAT_ACK 8'h50
`define IMSH_SC_MR_DAT_NACK 8'h58
`define IMSH_SC_SR_SLA_ACK 8'h60
`define IMSH_SC_SR_GC_ACK 8'h70
`define IMSH_SC_ST_SLA_ACK 8'ha8
`define IMSH_SC_NONE 8'hf8

// Reset values and the broadcast address
`define IMSH_RATE_RST 8'h10
`define IMSH_BYTE_RST 8'h00
`define IMSH_GC_ADDR 8'h00

// Byte framing: eight data bits, then the acknowledge bit
`define IMSH_BITS_PER_BYTE 4'h8
`define IMSH_BIT_STEP 4'h1
`define IMSH_CNT_STEP 8'h01

`endif

// *** imsh_pkg.sv ***
// Types shared by the two-wire bus controller.
// Assumes imsh_cfg.svh sits in the same folder.
`include "imsh_cfg.svh"

package imsh_pkg;

	// Bit engine states on the link clock
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_START = 4'h1,
		ST_LOW = 4'h2,
		ST_HIGH = 4'h3,
		ST_HOLD = 4'h4,
		ST_STOP_A = 4'h5,
		ST_STOP_B = 4'h6,
		ST_RS_A = 4'h7,
		ST_RS_B = 4'h8,
		ST_SLV = 4'h9,
		ST_SACK = 4'ha
	} imsh_state_e;

	// Snapshot of software state sent to the link domain
	typedef struct packed {
		logic en;
		logic aa;
		logic bus_begin_request;
		logic halt_request;
		logic si;
		logic ev_seen;
		logic gc;
		logic [6:0] own;
		logic [7:0] rate_hi;
		logic [7:0] rate_lo;
		logic [7:0] data;
	} imsh_cfg_s;

	// Event word returned from the link domain
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] data;
		logic set_flag;
	} imsh_ev_s;

endpackage : imsh_pkg

// *** imsh_top.sv ***
// Two-wire bus controller: software control bits on mclk, bit engine on the link clock.
// Assumes open-drain pins resolved outside; writes are one-cycle pulses.
//
// Overview of operation
// - Enabled device recognises own or broadcast address
// - Pending flag always pairs with one condition code
// - Set 0x44 enables block and acknowledge together
// - Set 0x40 enables block for master only
// - Set 0x20 requests a START condition
// - Clear write removes flag and chosen bits
// - Set 0x14 requests STOP with acknowledge enable
// - Set 0x24 restarts once bus is free
// - Set 0x04 makes received bytes acknowledged
// - Code 0x08 reports START; address follows
// - Code 0x10 reports repeated START; address follows
// - Address direction bit selects transmit or receive codes
// - Code 0x18: write address acknowledged
// - Code 0x20: write address not acknowledged
// - Code 0x28: data byte acknowledged
// - Code 0x30: data byte not acknowledged
// - Lost arbitration gives 0x38, releases bus
// - Code 0x40: read address acknowledged
// - Code 0x48: read address not acknowledged
// - Two rate fields set the serial clock
// - Bus error releases lines, flags, loads 0x00
// - Code 0xf8 while the flag is clear
`include "imsh_cfg.svh"

module imsh_top
	import imsh_pkg::*;
#(
	parameter int RATE_W = 8
) (
	// Clocks and reset
	input wire logic mclk_in,
	input wire logic link_clk_in,
	input wire logic rst_b_in,
	// Software control writes (mclk domain)
	input wire logic ctl_set_wr_in,
	input wire logic ctl_clr_wr_in,
	input wire logic [7:0] ctl_wdata_in,
	input wire logic data_wr_in,
	input wire logic [7:0] data_wdata_in,
	input wire logic own_wr_in,
	input wire logic [7:0] own_wdata_in,
	input wire logic rate_wr_in,
	input wire logic [RATE_W-1:0] rate_high_wdata_in,
	input wire logic [RATE_W-1:0] rate_low_wdata_in,
	// Software visible state (mclk domain)
	output logic [7:0] control_reg_out,
	output logic [7:0] condition_code_out,
	output logic [7:0] shift_byte_out,
	// Open-drain bus pins (link domain)
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_b_out,
	output logic sda_out,
	output logic sda_oe_b_out
);

	// mclk domain state
	logic [1:0] mrst_q; // Reset release synchroniser
	logic mrst_b;
	logic en_q, aa_q, sta_q, sto_q, si_q; // Control bits
	logic [7:0] code_q; // Condition code
	logic [7:0] data_q; // Shift byte seen by software
	logic [7:0] own_q; // Own address, broadcast accept in bit 0
	logic [RATE_W-1:0] rate_hi_q, rate_lo_q; // Clock rate fields
	logic ev_seen_q; // Last event toggle taken in
	logic hs_busy_q; // Snapshot in flight
	logic req_tog_q; // Snapshot request toggle
	imsh_cfg_s hold_q; // Snapshot, stable while in flight
	logic [2:0] ack_sync_q; // Ack toggle: two sync flops plus history
	logic [2:0] ev_sync_q; // Event toggle: two sync flops plus history
	logic ack_edge, ev_edge;

	// Link domain state
	logic [1:0] lrst_q;
	logic lrst_b;
	logic [2:0] req_sync_q;
	logic req_edge;
	imsh_cfg_s cfg_q; // Last snapshot taken
	logic ack_tog_q;
	logic [1:0] scl_sync_q, sda_sync_q; // Pin synchronisers
	logic scl_s, sda_s, scl_p_q, sda_p_q;
	logic start_det, stop_det, released;
	imsh_state_e state_q;
	logic [RATE_W-1:0] cnt_q; // Phase timer
	logic [3:0] bit_q; // Bit index in the nine-bit frame
	logic [7:0] shift_q;
	logic master_q, addr_q, rx_q, rs_q, busy_q;
	logic ev_tog_q;
	imsh_ev_s ev_q;
	logic scl_oe_b_q, sda_oe_b_q, pin_lvl_q;
	logic tx_now, slv_own, slv_gc;

	// Condition code of a finished master byte
	function automatic logic [7:0] done_code(input logic adr, input logic rx, input logic ack);
		if (adr) begin
			if (rx) begin
				done_code = ack ? `IMSH_SC_MR_SLA_ACK : `IMSH_SC_MR_SLA_NACK;
			end else begin
				done_code = ack ? `IMSH_SC_MT_SLA_ACK : `IMSH_SC_MT_SLA_NACK;
			end
		end else if (rx) begin
			done_code = ack ? `IMSH_SC_MR_DAT_ACK : `IMSH_SC_MR_DAT_NACK;
		end else begin
			done_code = ack ? `IMSH_SC_MT_DAT_ACK : `IMSH_SC_MT_DAT_NACK;
		end
	endfunction

	// Reset release for the mclk domain
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mrst_q <= 2'h0;
		end else begin
			mrst_q <= {mrst_q[0], 1'b1};
		end
	end
	assign mrst_b = mrst_q[1];

	// Toggle synchronisers into mclk; the second flop and the history flop feed the edge logic
	always_ff @(posedge mclk_in or negedge mrst_b) begin
		if (!mrst_b) begin
			ack_sync_q <= 3'h0;
			ev_sync_q <= 3'h0;
		end else begin
			ack_sync_q <= {ack_sync_q[1:0], ack_tog_q};
			ev_sync_q <= {ev_sync_q[1:0], ev_tog_q};
		end
	end
	assign ack_edge = ack_sync_q[1] ^ ack_sync_q[2];
	assign ev_edge = ev_sync_q[1] ^ ev_sync_q[2];

	// Control bits: set and clear writes; hardware stop-done wins
	always_ff @(posedge mclk_in or negedge mrst_b) begin
		if (!mrst_b) begin
			en_q <= 1'b0;
			aa_q <= 1'b0;
			sta_q <= 1'b0;
			sto_q <= 1'b0;
		end else begin
			if (ctl_set_wr_in) begin
				// 0x44, 0x40, 0x20, 0x14, 0x24 and 0x04 are all plain bit sets
				en_q <= en_q | ctl_wdata_in[`IMSH_BIT_EN];
				aa_q <= aa_q | ctl_wdata_in[`IMSH_BIT_AA];
				sta_q <= sta_q | ctl_wdata_in[`IMSH_BIT_STA];
				sto_q <= sto_q | ctl_wdata_in[`IMSH_BIT_STO];
			end else if (ctl_clr_wr_in) begin
				en_q <= en_q & ~ctl_wdata_in[`IMSH_BIT_EN];
				aa_q <= aa_q & ~ctl_wdata_in[`IMSH_BIT_AA];
				sta_q <= sta_q & ~ctl_wdata_in[`IMSH_BIT_STA];
				sto_q <= sto_q & ~ctl_wdata_in[`IMSH_BIT_STO];
			end
			// Stop finished on the bus: hardware drops the stop request
			if (ev_edge && !ev_q.set_flag) begin
				sto_q <= 1'b0;
			end
		end
	end

	// Interrupt flag and condition code move together
	always_ff @(posedge mclk_in or negedge mrst_b) begin
		if (!mrst_b) begin
			si_q <= 1'b0;
			code_q <= `IMSH_SC_NONE;
			ev_seen_q <= 1'b0;
		end else begin
			if (ctl_clr_wr_in && ctl_wdata_in[`IMSH_BIT_SI]) begin
				si_q <= 1'b0;
				code_q <= `IMSH_SC_NONE;
			end
			if (ev_edge) begin
				// Event word is stable: the engine waits for our answer
				ev_seen_q <= ev_sync_q[1];
				if (ev_q.set_flag) begin
					si_q <= 1'b1;
					code_q <= ev_q.code;
				end
			end
		end
	end

	// Shift byte: software writes, received bytes overwrite on the event
	always_ff @(posedge mclk_in or negedge mrst_b) begin
		if (!mrst_b) begin
			data_q <= `IMSH_BYTE_RST;
		end else if (ev_edge && ev_q.set_flag) begin
			data_q <= ev_q.data;
		end else if (data_wr_in) begin
			data_q <= data_wdata_in;
		end
	end

	// Own address and clock rate fields
	always_ff @(posedge mclk_in or negedge mrst_b) begin
		if (!mrst_b) begin
			own_q <= `IMSH_BYTE_RST;
			rate_hi_q <= RATE_W'(`IMSH_RATE_RST);
			rate_lo_q <= RATE_W'(`IMSH_RATE_RST);
		end else begin
			if (own_wr_in) begin
				own_q <= own_wdata_in;
			end
			if (rate_wr_in) begin
				rate_hi_q <= rate_high_wdata_in;
				rate_lo_q <= rate_low_wdata_in;
			end
		end
	end

	// Snapshot handshake: one word in flight, resent once acknowledged
	always_ff @(posedge mclk_in or negedge mrst_b) begin
		if (!mrst_b) begin
			hs_busy_q <= 1'b0;
			req_tog_q <= 1'b0;
			hold_q <= '0;
		end else if (!hs_busy_q) begin
			hold_q <= '{en: en_q, aa: aa_q, bus_begin_request: sta_q, halt_request: sto_q, si: si_q,
				ev_seen: ev_seen_q, gc: own_q[0], own: own_q[7:1],
				rate_hi: 8'(rate_hi_q), rate_lo: 8'(rate_lo_q), data: data_q};
			req_tog_q <= ~req_tog_q;
			hs_busy_q <= 1'b1;
		end else if (ack_edge) begin
			hs_busy_q <= 1'b0;
		end
	end

	// Software visible outputs are flop bits
	assign control_reg_out = {1'b0, en_q, sta_q, sto_q, si_q, aa_q, 2'h0};
	assign condition_code_out = code_q;
	assign shift_byte_out = data_q;

	// Reset release for the link domain
	always_ff @(posedge link_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lrst_q <= 2'h0;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end
	assign lrst_b = lrst_q[1];

	// Pin and request synchronisers on the link clock
	always_ff @(posedge link_clk_in or negedge lrst_b) begin
		if (!lrst_b) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			req_sync_q <= 3'h0;
			ack_tog_q <= 1'b0;
			cfg_q <= '0;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_in};
			sda_sync_q <= {sda_sync_q[0], sda_in};
			scl_p_q <= scl_sync_q[1];
			sda_p_q <= sda_sync_q[1];
			req_sync_q <= {req_sync_q[1:0], req_tog_q};
			if (req_edge) begin
				cfg_q <= hold_q;
				ack_tog_q <= ~ack_tog_q;
			end
		end
	end
	assign req_edge = req_sync_q[1] ^ req_sync_q[2];
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
	// Our last event seen and flag cleared; stale snapshots ignored
	assign released = (cfg_q.ev_seen == ev_tog_q) && !cfg_q.si;
	assign tx_now = addr_q | ~rx_q;
	assign slv_own = (shift_q[7:1] == cfg_q.own);
	assign slv_gc = cfg_q.gc && (shift_q == `IMSH_GC_ADDR);

	// Bit engine
	always_ff @(posedge link_clk_in or negedge lrst_b) begin
		if (!lrst_b) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			bit_q <= 4'h0;
			shift_q <= `IMSH_BYTE_RST;
			master_q <= 1'b0;
			addr_q <= 1'b0;
			rx_q <= 1'b0;
			rs_q <= 1'b0;
			busy_q <= 1'b0;
			ev_tog_q <= 1'b0;
			ev_q <= '0;
			scl_oe_b_q <= 1'b1;
			sda_oe_b_q <= 1'b1;
			pin_lvl_q <= 1'b0;
		end else begin
			pin_lvl_q <= 1'b0;
			// Bus busy between any START and STOP seen on the wires
			if (start_det) begin
				busy_q <= 1'b1;
			end else if (stop_det) begin
				busy_q <= 1'b0;
			end
			if (!cfg_q.en) begin
				// Disabled: lines released, only the busy flag still follows the wires
				state_q <= ST_IDLE;
				master_q <= 1'b0;
				scl_oe_b_q <= 1'b1;
				sda_oe_b_q <= 1'b1;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						scl_oe_b_q <= 1'b1;
						sda_oe_b_q <= 1'b1;
						if (released && cfg_q.halt_request) begin
							// Stop request outside a transfer: no STOP on the wires,
							// bus treated as free and the request dropped
							busy_q <= 1'b0;
							master_q <= 1'b0;
							ev_q <= '{code: `IMSH_SC_NONE, data: shift_q, set_flag: 1'b0};
							ev_tog_q <= ~ev_tog_q;
						end else if (released && cfg_q.bus_begin_request && !busy_q && sda_s) begin
							sda_oe_b_q <= 1'b0;
							cnt_q <= RATE_W'(cfg_q.rate_hi);
							rs_q <= 1'b0;
							master_q <= 1'b1;
							state_q <= ST_START;
						end else if (released && start_det) begin
							bit_q <= 4'h0;
							state_q <= ST_SLV;
						end
					end
					ST_START: begin
						// SDA low with SCL high, then SCL low and stall
						if (cnt_q == '0) begin
							scl_oe_b_q <= 1'b0;
							addr_q <= 1'b1;
							ev_q <= '{code: rs_q ? `IMSH_SC_RSTART : `IMSH_SC_START,
								data: shift_q, set_flag: 1'b1};
							ev_tog_q <= ~ev_tog_q;
							state_q <= ST_HOLD;
						end else begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end
					end
					ST_HOLD: begin
						// Clock held low until software answers
						scl_oe_b_q <= 1'b0;
						sda_oe_b_q <= 1'b1;
						if (released) begin
							cnt_q <= RATE_W'(cfg_q.rate_lo);
							if (!master_q) begin
								scl_oe_b_q <= 1'b1;
								state_q <= ST_IDLE;
							end else if (cfg_q.halt_request) begin
								sda_oe_b_q <= 1'b0;
								state_q <= ST_STOP_A;
							end else if (cfg_q.bus_begin_request) begin
								sda_oe_b_q <= 1'b1;
								state_q <= ST_RS_A;
							end else begin
								shift_q <= cfg_q.data;
								if (addr_q) begin
									rx_q <= cfg_q.data[0];
								end
								bit_q <= 4'h0;
								state_q <= ST_LOW;
							end
						end
					end
					ST_LOW: begin
						// Data changes only while SCL is low
						if (bit_q < `IMSH_BITS_PER_BYTE) begin
							sda_oe_b_q <= tx_now ? shift_q[7] : 1'b1;
						end else begin
							sda_oe_b_q <= tx_now ? 1'b1 : ~cfg_q.aa;
						end
						if (cnt_q == '0) begin
							scl_oe_b_q <= 1'b1;
							cnt_q <= RATE_W'(cfg_q.rate_hi);
							state_q <= ST_HIGH;
						end else begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end
					end
					ST_HIGH: begin
						if (!scl_s) begin
							// Another party stretches the clock: the high time waits
							cnt_q <= cnt_q;
						end else if (scl_p_q && sda_s != sda_p_q) begin
							// START or STOP inside a bit: bus error
							scl_oe_b_q <= 1'b1;
							sda_oe_b_q <= 1'b1;
							master_q <= 1'b0;
							ev_q <= '{code: `IMSH_SC_BUS_ERR, data: shift_q, set_flag: 1'b1};
							ev_tog_q <= ~ev_tog_q;
							state_q <= ST_IDLE;
						end else if (cnt_q != '0) begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end else if (tx_now && bit_q < `IMSH_BITS_PER_BYTE && sda_oe_b_q && !sda_s) begin
							// Sent a one, read a zero: another master wins
							scl_oe_b_q <= 1'b1;
							sda_oe_b_q <= 1'b1;
							master_q <= 1'b0;
							ev_q <= '{code: `IMSH_SC_ARB_LOST, data: shift_q, set_flag: 1'b1};
							ev_tog_q <= ~ev_tog_q;
							state_q <= ST_IDLE;
						end else begin
							scl_oe_b_q <= 1'b0;
							cnt_q <= RATE_W'(cfg_q.rate_lo);
							bit_q <= bit_q + `IMSH_BIT_STEP;
							if (bit_q < `IMSH_BITS_PER_BYTE) begin
								shift_q <= {shift_q[6:0], sda_s};
								state_q <= ST_LOW;
							end else begin
								addr_q <= 1'b0;
								ev_q <= '{code: done_code(addr_q, rx_q, tx_now ? ~sda_s : cfg_q.aa),
									data: shift_q, set_flag: 1'b1};
								ev_tog_q <= ~ev_tog_q;
								state_q <= ST_HOLD;
							end
						end
					end
					ST_STOP_A: begin
						// SDA low with SCL low, then release SCL
						if (cnt_q == '0) begin
							scl_oe_b_q <= 1'b1;
							cnt_q <= RATE_W'(cfg_q.rate_hi);
							state_q <= ST_STOP_B;
						end else begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end
					end
					ST_STOP_B: begin
						// SDA rises while SCL high: STOP; flag stays clear
						if (scl_s && cnt_q != '0) begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end else if (scl_s) begin
							sda_oe_b_q <= 1'b1;
							master_q <= 1'b0;
							ev_q <= '{code: `IMSH_SC_NONE, data: shift_q, set_flag: 1'b0};
							ev_tog_q <= ~ev_tog_q;
							state_q <= ST_IDLE;
						end
					end
					ST_RS_A: begin
						// SDA released with SCL low ahead of the repeated START
						if (cnt_q == '0) begin
							scl_oe_b_q <= 1'b1;
							cnt_q <= RATE_W'(cfg_q.rate_hi);
							state_q <= ST_RS_B;
						end else begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end
					end
					ST_RS_B: begin
						if (scl_s && cnt_q != '0) begin
							cnt_q <= cnt_q - RATE_W'(`IMSH_CNT_STEP);
						end else if (scl_s) begin
							sda_oe_b_q <= 1'b0;
							cnt_q <= RATE_W'(cfg_q.rate_hi);
							rs_q <= 1'b1;
							state_q <= ST_START;
						end
					end
					ST_SLV: begin
						// Watch an address byte sent by another master
						if (stop_det) begin
							state_q <= ST_IDLE;
						end else if (scl_s && !scl_p_q && bit_q < `IMSH_BITS_PER_BYTE) begin
							shift_q <= {shift_q[6:0], sda_s};
							bit_q <= bit_q + `IMSH_BIT_STEP;
						end else if (!scl_s && scl_p_q && bit_q == `IMSH_BITS_PER_BYTE) begin
							if (cfg_q.aa && (slv_own || slv_gc)) begin
								sda_oe_b_q <= 1'b0;
								ev_q <= '{code: slv_gc ? `IMSH_SC_SR_GC_ACK :
									(shift_q[0] ? `IMSH_SC_ST_SLA_ACK : `IMSH_SC_SR_SLA_ACK),
									data: shift_q, set_flag: 1'b1};
								state_q <= ST_SACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_SACK: begin
						// Acknowledge held through one clock; then stall and report
						if (!scl_s && scl_p_q) begin
							sda_oe_b_q <= 1'b1;
							scl_oe_b_q <= 1'b0;
							ev_tog_q <= ~ev_tog_q;
							state_q <= ST_HOLD;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Pins: level is always low, enable low pulls the line
	assign scl_out = pin_lvl_q;
	assign sda_out = pin_lvl_q;
	assign scl_oe_b_out = scl_oe_b_q;
	assign sda_oe_b_out = sda_oe_b_q;

endmodule // imsh_top

// *** imsh_top_properties.sv ***
// Port checker for the bus controller, mclk domain only.
// Assumes a bind to imsh_top; sees its ports only.
module imsh_top_properties (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Control writes
	input wire logic ctl_set_wr_in,
	input wire logic ctl_clr_wr_in,
	input wire logic [7:0] ctl_wdata_in,
	// Visible state and pins
	input wire logic [7:0] control_reg_out,
	input wire logic [7:0] condition_code_out,
	input wire logic scl_oe_b_out,
	input wire logic sda_oe_b_out
);
	// Sampled on mclk, paused in reset
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	property p_idle_code;
		!control_reg_out[3] |-> condition_code_out == 8'hf8;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle code wrong");
	property p_en_ack;
		ctl_set_wr_in && ctl_wdata_in == 8'h44 |=> control_reg_out[6] && control_reg_out[2];
	endproperty
	a_en_ack: assert property (p_en_ack) else $error("enable with ack failed");
	// Acknowledge enable kept
	property p_en_only;
		ctl_set_wr_in && ctl_wdata_in == 8'h40
			|=> control_reg_out[6] && control_reg_out[2] == $past(control_reg_out[2]);
	endproperty
	a_en_only: assert property (p_en_only) else $error("enable only failed");
	property p_start_req;
		ctl_set_wr_in && ctl_wdata_in[5] |-> ##1 control_reg_out[5];
	endproperty
	a_start_req: assert property (p_start_req) else $error("start request lost");
	// No event lands while the flag is set
	property p_clear;
		ctl_clr_wr_in && !ctl_set_wr_in && ctl_wdata_in == 8'h08 && control_reg_out[3]
			|=> !control_reg_out[3] && condition_code_out == 8'hf8;
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear failed");
	property p_stop_req;
		ctl_set_wr_in && ctl_wdata_in == 8'h14 |=> control_reg_out[4] && control_reg_out[2];
	endproperty
	a_stop_req: assert property (p_stop_req) else $error("stop request lost");
	property p_restart;
		ctl_set_wr_in && ctl_wdata_in == 8'h24 |=> control_reg_out[5] && control_reg_out[2];
	endproperty
	a_restart: assert property (p_restart) else $error("restart request lost");
	property p_ack_bit;
		ctl_set_wr_in && ctl_wdata_in[2] |-> ##1 control_reg_out[2];
	endproperty
	a_ack_bit: assert property (p_ack_bit) else $error("ack enable lost");
	property p_flag_code;
		$rose(control_reg_out[3]) |-> condition_code_out[2:0] == 3'h0 && condition_code_out != 8'hf8;
	endproperty
	a_flag_code: assert property (p_flag_code) else $error("flag without code");
	// Codes 0x00 and 0x38 release the bus, others stall SCL
	property p_hold_scl;
		control_reg_out[3] && control_reg_out[6] && condition_code_out != 8'h00
			&& condition_code_out != 8'h38 |-> !scl_oe_b_out;
	endproperty
	a_hold_scl: assert property (p_hold_scl) else $error("clock not stalled");
	property p_release;
		control_reg_out[3] && (condition_code_out == 8'h38 || condition_code_out == 8'h00)
			|-> scl_oe_b_out && sda_oe_b_out;
	endproperty
	a_release: assert property (p_release) else $error("bus not released");
endmodule // imsh_top_properties

bind imsh_top imsh_top_properties u_props (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
	.ctl_set_wr_in(ctl_set_wr_in), .ctl_clr_wr_in(ctl_clr_wr_in), .ctl_wdata_in(ctl_wdata_in),
	.control_reg_out(control_reg_out), .condition_code_out(condition_code_out),
	.scl_oe_b_out(scl_oe_b_out), .sda_oe_b_out(sda_oe_b_out));

// *** imsh_slave_model.sv ***
// Behavioural target device on the two-wire bus.
// Assumes wired-AND lines with pull-ups.
module imsh_slave_model #(
	parameter logic [6:0] ADDR = 7'h5a, // Address this target answers to
	parameter int STRETCH_NS = 200 // Stretch when slow
) (
	// Resolved lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Behaviour knobs
	input wire logic ack_addr_in,
	input wire logic ack_data_in,
	input wire logic slow_in,
	input wire logic [7:0] rd_byte_in,
	// Line releases, low pulls the line; last byte written to us
	output logic scl_rel_out,
	output logic sda_rel_out,
	output logic [7:0] last_byte_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// One frame, MSB first, ninth clock acks
	task automatic run_frame();
		logic [7:0] b;
		logic hit;
		logic rd;
		hit = 1'b0;
		rd = 1'b0;
		for (int n = 0; n < 64; n++) begin
			for (int i = 7; i >= 0; i--) begin
				sda_rel_out = rd ? rd_byte_in[i] : 1'b1;
				@(posedge scl_in);
				b[i] = sda_in;
				@(negedge scl_in);
			end
			if (n == 0) begin
				hit = (b[7:1] == ADDR) && ack_addr_in;
				rd = b[0] && hit;
			end else if (!rd) begin
				last_byte_out = b;
			end
			// Reader leaves the ack to the master
			sda_rel_out = (n == 0) ? !hit : (rd ? 1'b1 : !(hit && ack_data_in));
			@(posedge scl_in);
			// A master NACK ends our reply
			if (rd && n > 0 && sda_in) {rd, hit} = 2'b00;
			@(negedge scl_in);
			sda_rel_out = 1'b1;
			if (slow_in) begin
				scl_rel_out = 1'b0;
				#(STRETCH_NS);
				scl_rel_out = 1'b1;
			end
		end
	endtask

	// Frames run from START to START or STOP
	initial begin
		scl_rel_out = 1'b1;
		sda_rel_out = 1'b1;
		last_byte_out = 8'h00;
		forever begin
			if (!(scl_in === 1'b1 && sda_in === 1'b0)) @(negedge sda_in iff scl_in === 1'b1);
			fork
				run_frame();
				@(sda_in iff scl_in === 1'b1);
			join_any
			disable fork;
			sda_rel_out = 1'b1;
			scl_rel_out = 1'b1;
		end
	end
endmodule // imsh_slave_model

// *** imsh_top_tb.sv ***
// Self-checking bench for the two-wire bus controller.
// Assumes every other file is compiled with it.
module imsh_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] TGT = 7'h5a; // Leading one loses arbitration
	logic mclk_in, link_clk, rst_b;
	logic [4:0] stb; // Strobes: set, clear, data, own, rate
	logic [7:0] wv; // One write value feeds all data buses
	logic [7:0] control_reg_out, condition_code_out, shift_byte_out, slv_byte;
	logic scl_o, scl_oe_b, sda_o, sda_oe_b, slv_scl_rel, slv_sda_rel, tb_sda_rel;
	logic ack_addr, ack_data, slow;
	wire logic scl_w, sda_w;
	int bad_count, total_checks;
	// Wired-AND with pull-ups
	assign scl_w = (scl_oe_b | scl_o) & slv_scl_rel;
	assign sda_w = (sda_oe_b | sda_o) & slv_sda_rel & tb_sda_rel;

	imsh_top #(.RATE_W(8)) u_dut (
		.mclk_in(mclk_in), .link_clk_in(link_clk), .rst_b_in(rst_b),
		.ctl_set_wr_in(stb[0]), .ctl_clr_wr_in(stb[1]), .ctl_wdata_in(wv),
		.data_wr_in(stb[2]), .data_wdata_in(wv), .own_wr_in(stb[3]), .own_wdata_in(wv),
		.rate_wr_in(stb[4]), .rate_high_wdata_in(wv), .rate_low_wdata_in(wv),
		.control_reg_out(control_reg_out), .condition_code_out(condition_code_out),
		.shift_byte_out(shift_byte_out), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o),
		.scl_oe_b_out(scl_oe_b), .sda_out(sda_o), .sda_oe_b_out(sda_oe_b));
	imsh_slave_model #(.ADDR(TGT)) u_slave (.scl_in(scl_w), .sda_in(sda_w),
		.ack_addr_in(ack_addr), .ack_data_in(ack_data), .slow_in(slow), .rd_byte_in(8'hc3),
		.scl_rel_out(slv_scl_rel), .sda_rel_out(slv_sda_rel), .last_byte_out(slv_byte));

	// Clocks with unrelated phases
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One-cycle strobe k carrying v
	task automatic wr(input int k, input logic [7:0] v);
		@(posedge mclk_in);
		#1;
		wv = v;
		stb[k] = 1'b1;
		@(posedge mclk_in);
		#1;
		stb = 5'h00;
	endtask
	// Bounded wait: a dead bus mismatches
	task automatic wait_si(input logic [7:0] code);
		int n;
		n = 0;
		while (control_reg_out[3] !== 1'b1 && n < 8000) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		chk("code", condition_code_out, code);
	endtask
	task automatic nxt(input logic [7:0] c, input logic [7:0] code);
		wr(1, c);
		wait_si(code);
	endtask
	// Clearing start too avoids a repeated START
	task automatic open_xfer(input logic dir, input logic [7:0] code);
		wr(0, 8'h20);
		wait_si(8'h08);
		wr(2, {TGT, dir});
		nxt(8'h28, code);
	endtask
	task automatic stop_bus();
		int n;
		n = 0;
		wr(0, 8'h14);
		wr(1, 8'h08);
		while (control_reg_out[4] !== 1'b0 && n < 8000) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		chk("stop request", {3'h0, control_reg_out[4], 4'h0}, 8'h00);
		chk("code", condition_code_out, 8'hf8);
		chk("data line", {7'h00, sda_w}, 8'h01);
	endtask

	task automatic t_control();
		chk("control", control_reg_out, 8'h00);
		chk("code", condition_code_out, 8'hf8);
		wr(0, 8'h40);
		chk("control", control_reg_out, 8'h40);
		wr(0, 8'h04);
		chk("control", control_reg_out, 8'h44);
		wr(1, 8'h44);
		chk("control", control_reg_out, 8'h00);
		wr(0, 8'h44);
		chk("control", control_reg_out, 8'h44);
		$display("control test done");
	endtask
	task automatic t_write();
		open_xfer(1'b0, 8'h18);
		wr(2, 8'ha5);
		nxt(8'h08, 8'h28);
		chk("target byte", slv_byte, 8'ha5);
		ack_data = 1'b0;
		wr(2, 8'h3c);
		nxt(8'h08, 8'h30);
		ack_data = 1'b1;
		stop_bus();
		$display("write test done");
	endtask
	// Slow target, repeated START, reads
	task automatic t_read();
		slow = 1'b1;
		open_xfer(1'b0, 8'h18);
		wr(0, 8'h20);
		nxt(8'h08, 8'h10);
		wr(2, {TGT, 1'b1});
		nxt(8'h28, 8'h40);
		nxt(8'h08, 8'h50);
		chk("shift byte", shift_byte_out, 8'hc3);
		wr(1, 8'h04);
		nxt(8'h08, 8'h58);
		stop_bus();
		slow = 1'b0;
		$display("read test done");
	endtask
	task automatic t_nack();
		ack_addr = 1'b0;
		open_xfer(1'b0, 8'h20);
		stop_bus();
		open_xfer(1'b1, 8'h48);
		stop_bus();
		ack_addr = 1'b1;
		$display("nack test done");
	endtask
	// Another master holds SDA low; release is a STOP
	task automatic t_arb();
		wr(0, 8'h20);
		wait_si(8'h08);
		wr(2, {TGT, 1'b0});
		tb_sda_rel = 1'b0;
		nxt(8'h28, 8'h38);
		chk("released lines", {6'h00, scl_oe_b, sda_oe_b}, 8'h03);
		wr(0, 8'h24);
		wr(1, 8'h08);
		tb_sda_rel = 1'b1;
		wait_si(8'h08);
		wr(2, {TGT, 1'b0});
		nxt(8'h28, 8'h18);
		stop_bus();
		$display("arbitration test done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog, well past the run
	initial begin
		#300us;
		bad_count++;
		$display("Error watchdog expected finish seen hang");
		complete_run();
	end
	initial begin
		{rst_b, stb, wv, slow} = 15'h0;
		{tb_sda_rel, ack_addr, ack_data} = 3'h7;
		bad_count = 0;
		total_checks = 0;
		// Spans both domains
		repeat (8) @(posedge link_clk);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge mclk_in);
		wr(3, 8'h24);
		wr(4, 8'h03);
		t_control();
		t_write();
		t_read();
		t_nack();
		t_arb();
		complete_run();
	end
endmodule // imsh_top_tb
